// *** src/emx_map.vh ***
// Register map, field positions, opcodes and reset values of the extended memory-op execute block.
`ifndef EMX_MAP_VH
`define EMX_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define EMX_OFF_CMD       12'h000
`define EMX_OFF_ACC       12'h004
`define EMX_OFF_FLAGS     12'h008
`define EMX_OFF_PTR_LO    12'h00C
`define EMX_OFF_PTR_HI    12'h010
`define EMX_OFF_HI_LATCH  12'h014
`define EMX_OFF_MEM_BASE  12'h040
`define EMX_MEM_WORDS     16

// ****************************************************************
// Command register fields
// ****************************************************************
`define EMX_CMD_OP_MSB    3
`define EMX_CMD_OP_LSB    0
`define EMX_CMD_BIT_MSB   6
`define EMX_CMD_BIT_LSB   4
`define EMX_CMD_ADR_MSB   11
`define EMX_CMD_ADR_LSB   8
`define EMX_STAT_BUSY     0
`define EMX_STAT_SKIP     1

// ****************************************************************
// Flag bit positions
// ****************************************************************
`define EMX_FLG_C         0
`define EMX_FLG_AUX       1
`define EMX_FLG_Z         2
`define EMX_FLG_OVF       3
`define EMX_FLG_SGN       4
`define EMX_FLG_CZERO     5

// ****************************************************************
// Opcodes
// ****************************************************************
`define EMX_OP_SUBM       4'h1
`define EMX_OP_SWAP       4'h2
`define EMX_OP_SWAPA      4'h3
`define EMX_OP_SZ         4'h4
`define EMX_OP_SZA        4'h5
`define EMX_OP_SZBIT      4'h6
`define EMX_OP_TABRD      4'h7
`define EMX_OP_TABRDL     4'h8
`define EMX_OP_ITABRD     4'h9
`define EMX_OP_ITABRDL    4'hA
`define EMX_OP_XOR        4'hB
`define EMX_OP_XORM       4'hC

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define EMX_RST_BYTE      8'h00
`define EMX_RST_FLAGS     6'h00
`define EMX_LAST_PAGE     8'hFF
`define EMX_DUMMY_CYCLES  1'h1

`endif

// *** src/emx_exec.v ***
// Execute unit for the extended memory-op instructions, with an APB register window.
//
// Notes on behaviour
// - Subtract memory from accumulator, result into memory, accumulator kept.
// - After subtract, carry is 0 if negative, 1 if zero or positive.
// - Subtract updates overflow, zero, aux carry, carry, signed carry, carry-zero.
// - In-place swap exchanges memory nibbles, writes back, flags untouched.
// - Swap to accumulator loads swapped memory nibbles, memory and flags kept.
// - Memory-zero skip rewrites the byte and skips when it is zero.
// - A taken skip inserts two dummy cycles; the instruction lasts three cycles.
// - Copy-and-skip loads accumulator from memory, skips when zero, no flags.
// - Bit-zero skip skips when the selected memory bit is zero.
// - Paged table read: word at high:low pointer, low byte to memory, high to latch.
// - Final-page table read uses low pointer on last page, same destinations.
// - Incrementing paged read bumps low pointer first, then reads with it.
// - Incrementing final-page read bumps low pointer first, then reads last page.
// - XOR to accumulator, only zero flag changes.
// - XOR to memory, only zero flag changes.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "emx_map.vh"

module emx_exec
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [15:0] prog_addr,
    input  wire [15:0] prog_data
);

    // ****************************************************************
    // State encoding
    // ****************************************************************
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_EXEC  = 4'b0010;
    localparam [3:0] ST_TREAD = 4'b0100;
    localparam [3:0] ST_DUMMY = 4'b1000;

    reg [3:0]  state;
    reg [7:0]  acc;
    reg [5:0]  flags;
    reg [7:0]  ptr_lo;
    reg [7:0]  ptr_hi;
    reg [7:0]  hi_latch;
    reg [7:0]  mem [0:`EMX_MEM_WORDS-1];
    reg [3:0]  cmd_op;
    reg [2:0]  cmd_bit;
    reg [3:0]  cmd_adr;
    reg        skip_pending;
    reg        dummy_cnt;
    integer    i;

    // ****************************************************************
    // Functions
    // ****************************************************************
    function [7:0] swap_nibbles;
        input [7:0] v;
        begin
            swap_nibbles = {v[3:0], v[7:4]};
        end
    endfunction

    function [15:0] table_address;
        input       final_page;
        input [7:0] high;
        input [7:0] low;
        begin
            table_address = final_page ? {`EMX_LAST_PAGE, low} : {high, low};
        end
    endfunction

    function is_mem_addr;
        input [11:0] a;
        begin
            is_mem_addr = (a >= `EMX_OFF_MEM_BASE) && (a < `EMX_OFF_MEM_BASE + 12'h040) && (a[1:0] == 2'b00);
        end
    endfunction

    // ****************************************************************
    // Operand and subtract datapath
    // ****************************************************************
    wire [7:0] operand   = mem[cmd_adr];
    wire [8:0] diff_full = {1'b0, acc} - {1'b0, operand};
    wire [4:0] diff_low  = {1'b0, acc[3:0]} - {1'b0, operand[3:0]};
    wire [7:0] diff      = diff_full[7:0];
    wire       diff_ov   = (acc[7] ^ operand[7]) & (acc[7] ^ diff[7]);
    wire [7:0] xor_val   = acc ^ operand;
    wire [7:0] ptr_inc   = ptr_lo + 8'h01;
    wire       busy      = (state != ST_IDLE);
    wire [3:0] mem_idx   = paddr[5:2];

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire setup   = psel & ~penable;
    wire access  = psel & penable & ce;
    wire mapped  = (paddr == `EMX_OFF_CMD) || (paddr == `EMX_OFF_ACC) || (paddr == `EMX_OFF_FLAGS) ||
                   (paddr == `EMX_OFF_PTR_LO) || (paddr == `EMX_OFF_PTR_HI) || (paddr == `EMX_OFF_HI_LATCH) ||
                   is_mem_addr(paddr);
    wire wr_ok   = access & pwrite & mapped;
    wire wr_idle = wr_ok & ~busy;

    assign pready  = ce;
    assign pslverr = psel & penable & ~mapped;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (ce && setup)
        begin
            prdata <= 32'h0000_0000;
            case (paddr)
                `EMX_OFF_CMD:   prdata[1:0] <= {skip_pending, busy};
                `EMX_OFF_ACC:   prdata[7:0] <= acc;
                `EMX_OFF_FLAGS: prdata[5:0] <= flags;
                `EMX_OFF_PTR_LO:   prdata[7:0] <= ptr_lo;
                `EMX_OFF_PTR_HI:   prdata[7:0] <= ptr_hi;
                `EMX_OFF_HI_LATCH: prdata[7:0] <= hi_latch;
                default:
                begin
                    if (is_mem_addr(paddr))
                        prdata[7:0] <= mem[mem_idx];
                end
            endcase
        end
    end

    // ****************************************************************
    // Sequencer and architectural state
    // ****************************************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state        <= ST_IDLE;
            acc          <= `EMX_RST_BYTE;
            flags        <= `EMX_RST_FLAGS;
            ptr_lo       <= `EMX_RST_BYTE;
            ptr_hi       <= `EMX_RST_BYTE;
            hi_latch     <= `EMX_RST_BYTE;
            cmd_op       <= 4'h0;
            cmd_bit      <= 3'h0;
            cmd_adr      <= 4'h0;
            skip_pending <= 1'b0;
            dummy_cnt    <= 1'b0;
            prog_addr    <= 16'h0000;
            for (i = 0; i < `EMX_MEM_WORDS; i = i + 1)
                mem[i] <= `EMX_RST_BYTE;
        end
        else if (ce)
        begin
            case (state)
                ST_IDLE:
                begin
                    if (wr_idle)
                    begin
                        case (paddr)
                            `EMX_OFF_CMD:
                            begin
                                if (skip_pending)
                                    skip_pending <= 1'b0;
                                else
                                begin
                                    cmd_op  <= pwdata[`EMX_CMD_OP_MSB:`EMX_CMD_OP_LSB];
                                    cmd_bit <= pwdata[`EMX_CMD_BIT_MSB:`EMX_CMD_BIT_LSB];
                                    cmd_adr <= pwdata[`EMX_CMD_ADR_MSB:`EMX_CMD_ADR_LSB];
                                    state   <= ST_EXEC;
                                end
                            end
                            `EMX_OFF_ACC:   acc   <= pwdata[7:0];
                            `EMX_OFF_FLAGS: flags <= pwdata[5:0];
                            `EMX_OFF_PTR_LO:   ptr_lo   <= pwdata[7:0];
                            `EMX_OFF_PTR_HI:   ptr_hi   <= pwdata[7:0];
                            `EMX_OFF_HI_LATCH: hi_latch <= hi_latch;
                            default:        mem[mem_idx] <= pwdata[7:0];
                        endcase
                    end
                end
                ST_EXEC:
                begin
                    state <= ST_IDLE;
                    case (cmd_op)
                        `EMX_OP_SUBM:
                        begin
                            mem[cmd_adr]         <= diff;
                            flags[`EMX_FLG_C]    <= ~diff_full[8];
                            flags[`EMX_FLG_AUX]   <= ~diff_low[4];
                            flags[`EMX_FLG_Z]     <= (diff == 8'h00);
                            flags[`EMX_FLG_OVF]   <= diff_ov;
                            flags[`EMX_FLG_SGN]   <= diff[7] ^ diff_ov;
                            flags[`EMX_FLG_CZERO] <= (diff == 8'h00);
                        end
                        `EMX_OP_SWAP:
                        begin
                            mem[cmd_adr] <= swap_nibbles(operand);
                        end
                        `EMX_OP_SWAPA:
                        begin
                            acc <= swap_nibbles(operand);
                        end
                        `EMX_OP_SZ:
                        begin
                            mem[cmd_adr] <= operand;
                            if (operand == 8'h00)
                            begin
                                state        <= ST_DUMMY;
                                dummy_cnt    <= 1'b0;
                                skip_pending <= 1'b1;
                            end
                        end
                        `EMX_OP_SZA:
                        begin
                            acc <= operand;
                            if (operand == 8'h00)
                            begin
                                state        <= ST_DUMMY;
                                dummy_cnt    <= 1'b0;
                                skip_pending <= 1'b1;
                            end
                        end
                        `EMX_OP_SZBIT:
                        begin
                            if (!operand[cmd_bit])
                            begin
                                state        <= ST_DUMMY;
                                dummy_cnt    <= 1'b0;
                                skip_pending <= 1'b1;
                            end
                        end
                        `EMX_OP_TABRD:
                        begin
                            prog_addr <= table_address(1'b0, ptr_hi, ptr_lo);
                            state     <= ST_TREAD;
                        end
                        `EMX_OP_TABRDL:
                        begin
                            prog_addr <= table_address(1'b1, ptr_hi, ptr_lo);
                            state     <= ST_TREAD;
                        end
                        `EMX_OP_ITABRD:
                        begin
                            ptr_lo    <= ptr_inc;
                            prog_addr <= table_address(1'b0, ptr_hi, ptr_inc);
                            state     <= ST_TREAD;
                        end
                        `EMX_OP_ITABRDL:
                        begin
                            ptr_lo    <= ptr_inc;
                            prog_addr <= table_address(1'b1, ptr_hi, ptr_inc);
                            state     <= ST_TREAD;
                        end
                        `EMX_OP_XOR:
                        begin
                            acc               <= xor_val;
                            flags[`EMX_FLG_Z] <= (xor_val == 8'h00);
                        end
                        `EMX_OP_XORM:
                        begin
                            mem[cmd_adr]      <= xor_val;
                            flags[`EMX_FLG_Z] <= (xor_val == 8'h00);
                        end
                        default:
                        begin
                            state <= ST_IDLE;
                        end
                    endcase
                end
                ST_TREAD:
                begin
                    // low byte to memory, high byte to latch
                    mem[cmd_adr] <= prog_data[7:0];
                    hi_latch     <= prog_data[15:8];
                    state        <= ST_IDLE;
                end
                ST_DUMMY:
                begin
                    if (dummy_cnt == `EMX_DUMMY_CYCLES)
                        state <= ST_IDLE;
                    dummy_cnt <= dummy_cnt + 1'b1;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // emx_exec
`default_nettype wire

// *** verif/emx_exec_asserts.sv ***
// Port-level assertions for the extended memory-op execute block.
`timescale 1ns/1ps
`default_nettype none
module emx_exec_asserts
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] prog_addr,
    input wire logic [15:0] prog_data
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [7:0] lo_ptr;
    logic [7:0] hi_ptr;
    wire        acc_ph = psel && penable && ce;
    wire        cmd_wr = acc_ph && pwrite && paddr == 12'h000;
    wire [3:0]  cmd_op = pwdata[3:0];
    wire        mapped = paddr[1:0] == 2'b00 &&
                         ((paddr[11:5] == 7'h00 && paddr[4:2] <= 3'h5) || paddr[11:6] == 6'h01);

    // Shadow of the table pointer, bumped by the preincrementing reads.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            lo_ptr <= 8'h00;
            hi_ptr <= 8'h00;
        end
        else
        begin
            if (acc_ph && pwrite && paddr == 12'h00C) lo_ptr <= pwdata[7:0];
            else if (cmd_wr && (cmd_op == 4'h9 || cmd_op == 4'hA)) lo_ptr <= lo_ptr + 8'h01;
            if (acc_ph && pwrite && paddr == 12'h010) hi_ptr <= pwdata[7:0];
        end

    a_ready_tracks_ce: assert property (pready == ce)
        else $error("pready differs from ce");
    a_err_unmapped: assert property (acc_ph && paddr[1:0] == 2'b00 && !mapped |-> pslverr)
        else $error("unmapped access without pslverr");
    a_err_mapped_quiet: assert property ((!(psel && penable) || mapped) |-> !pslverr)
        else $error("pslverr without unmapped access");
    a_rdata_upper_zero: assert property (prdata[31:8] == 24'h00_0000)
        else $error("prdata upper bits not zero");
    a_rdata_holds: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("prdata moved outside a setup cycle");
    a_freeze_prog_addr: assert property (!ce |=> $stable(prog_addr))
        else $error("prog_addr moved while ce low");
    a_paged_addr: assert property (
        cmd_wr && (cmd_op == 4'h7 || cmd_op == 4'h9) |-> ##2 prog_addr == {hi_ptr, lo_ptr})
        else $error("paged table address wrong");
    a_final_page_addr: assert property (
        cmd_wr && (cmd_op == 4'h8 || cmd_op == 4'hA) |-> ##2 prog_addr == {8'hFF, lo_ptr})
        else $error("final page table address wrong");
    a_addr_table_only: assert property (
        $changed(prog_addr) |-> $past(cmd_wr, 2) && $past(cmd_op, 2) >= 4'h7 && $past(cmd_op, 2) <= 4'hA)
        else $error("prog_addr moved without a table read");

    c_skip_cmd: cover property (cmd_wr && cmd_op == 4'h4);
    c_table_cmd: cover property (cmd_wr && cmd_op == 4'hA);
    c_bus_error: cover property (acc_ph && pslverr);
    c_ce_low: cover property (!ce);
endmodule // emx_exec_asserts

bind emx_exec emx_exec_asserts emx_exec_asserts_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data));
`default_nettype wire

// *** verif/emx_exec_tb.sv ***
// Self-checking testbench for the extended memory-op execute block.
`timescale 1ns/1ps
`default_nettype none
module emx_exec_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [15:0] prog_addr;
    wire  [15:0] prog_data;
    int          err_count = 0;
    int          cmp_count = 0;
    logic [31:0] rd;
    logic        last_err;

    always #10 pclk = ~pclk;
    // Program memory model: each word is its address with a fixed pattern folded in.
    assign prog_data = prog_addr ^ 16'hA53C;

    emx_exec emx_exec_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data));

    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One transfer; psel stays up so a following transfer may start at once.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        last_err = pslverr;
        penable <= 1'b0;
    endtask

    task automatic idle;
        psel <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [11:0] m(input logic [3:0] i);
        return {6'h01, i, 2'b00};
    endfunction

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
        idle();
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0000_0000);
        idle();
        chk(rd, {24'h00_0000, e});
    endtask

    // Issues a command and counts the status reads that still see it busy.
    task automatic run(input logic [3:0] op, input logic [2:0] b, input logic [3:0] i, output int busy);
        apb(1'b1, 12'h000, {20'h0_0000, i, 1'b0, b, op});
        busy = 0;
        do
        begin
            apb(1'b0, 12'h000, 32'h0000_0000);
            if (rd[0] === 1'b1) busy++;
        end
        while (rd[0] !== 1'b0);
        idle();
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        for (int a = 0; a <= 20; a += 4) rdchk(a[11:0], 8'h00);
        rdchk(m(4'hF), 8'h00);
    endtask

    task automatic t_sub;
        logic [7:0] av[3] = '{8'h20, 8'h50, 8'h80};
        logic [7:0] mv[3] = '{8'h30, 8'h50, 8'h01};
        logic [7:0] rv[3] = '{8'hF0, 8'h00, 8'h7F};
        logic [7:0] fv[3] = '{8'h12, 8'h27, 8'h19};
        int n;
        for (int i = 0; i < 3; i++)
        begin
            wr(12'h004, av[i]);
            wr(m(4'h2), mv[i]);
            run(4'h1, 3'h0, 4'h2, n);
            rdchk(m(4'h2), rv[i]);
            rdchk(12'h004, av[i]);
            rdchk(12'h008, fv[i]);
        end
    endtask

    task automatic t_swap;
        int n;
        wr(12'h008, 8'h15);
        wr(m(4'h3), 8'hA5);
        run(4'h2, 3'h0, 4'h3, n);
        rdchk(m(4'h3), 8'h5A);
        run(4'h3, 3'h0, 4'h3, n);
        rdchk(12'h004, 8'hA5);
        rdchk(m(4'h3), 8'h5A);
        rdchk(12'h008, 8'h15);
    endtask

    task automatic skip_case(input logic [3:0] op, input logic [2:0] b, input logic [7:0] v, input logic take);
        int n;
        logic [7:0] ab;
        ab = (op == 4'h5) ? v : 8'h33;
        wr(12'h004, 8'h33);
        wr(m(4'h5), v);
        run(op, b, 4'h5, n);
        chk(n, take ? 2 : 1);
        chk(rd[1], take);
        rdchk(m(4'h5), v);
        rdchk(12'h004, ab);
        run(4'hB, 3'h0, 4'h5, n);
        rdchk(12'h004, take ? ab : ab ^ v);
        rdchk(12'h000, 8'h00);
    endtask

    task automatic t_table;
        logic [7:0]  lo;
        logic [15:0] w;
        int          n;
        wr(12'h010, 8'h12);
        wr(12'h00C, 8'h34);
        for (int i = 0; i < 4; i++)
        begin
            lo = (i < 2) ? 8'h34 : 8'h33 + 8'(i);
            w = {i[0] ? 8'hFF : 8'h12, lo} ^ 16'hA53C;
            run(4'h7 + 4'(i), 3'h0, 4'h6 + 4'(i), n);
            rdchk(m(4'h6 + 4'(i)), w[7:0]);
            rdchk(12'h014, w[15:8]);
            rdchk(12'h00C, lo);
        end
        wr(12'h014, 8'h77);
        rdchk(12'h014, w[15:8]);
    endtask

    task automatic t_xor;
        int n;
        wr(12'h008, 8'h3F);
        wr(12'h004, 8'h0F);
        wr(m(4'hA), 8'hFF);
        run(4'hB, 3'h0, 4'hA, n);
        rdchk(12'h004, 8'hF0);
        rdchk(12'h008, 8'h3B);
        wr(m(4'hA), 8'hF0);
        run(4'hC, 3'h0, 4'hA, n);
        rdchk(m(4'hA), 8'h00);
        rdchk(12'h008, 8'h3F);
        rdchk(12'h004, 8'hF0);
    endtask

    task automatic t_bus;
        apb(1'b1, 12'h020, 32'h0000_00FF);
        chk(last_err, 1'b1);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(last_err, 1'b0);
        idle();
        ce <= 1'b0;
        repeat (4) @(posedge pclk);
        ce <= 1'b1;
        rdchk(12'h004, 8'hF0);
        // A write started while ce is low must wait for ce before it lands.
        fork
            apb(1'b1, 12'h004, 32'h0000_0055);
            begin
                ce <= 1'b0;
                repeat (4) @(posedge pclk);
                ce <= 1'b1;
            end
        join
        idle();
        rdchk(12'h004, 8'h55);
    endtask

    task automatic results;
        $display("comparisons=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_sub();
        t_swap();
        skip_case(4'h4, 3'h0, 8'h00, 1'b1);
        skip_case(4'h4, 3'h0, 8'h80, 1'b0);
        skip_case(4'h5, 3'h0, 8'h00, 1'b1);
        skip_case(4'h5, 3'h0, 8'h44, 1'b0);
        skip_case(4'h6, 3'h0, 8'hFE, 1'b1);
        skip_case(4'h6, 3'h7, 8'hFE, 1'b0);
        skip_case(4'h6, 3'h7, 8'h7F, 1'b1);
        t_table();
        t_xor();
        t_bus();
        results();
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        results();
    end
endmodule // emx_exec_tb
`default_nettype wire
